// >>> core/stall_params.svh
// Constants for the stall prevention block
// What this block does
// - Stall when current exceeds programmable percent level
// - Stall bends ramp: accel/const decelerate, decel accelerates
// - Overload indication follows active stall prevention
// - Indication stays on longer than 100 ms
// - Indication drops once current is back at level
// - Delay 0 immediate, tenths up to 25 s, 9999 none
// - Regeneration avoidance and overvoltage stall also indicate
// - Output terminal code 3 true, 103 inverted
// - Stall at 1 Hz for 3 s trips fault
// - Level reduced above start frequency by formula
// - Compensation 9999 keeps level constant to 400 Hz
// - Second function select picks second level
// - Input terminal code 3 is second function select
// - Selection 11 lowers voltage during stall
// - Selection weights 1,2,4 disable fast/accel/constant
// - Weight 16 stops drive on overload indication
// - Weight 8 disables decel; 100/101 by mode
// - Stop on overload raises stall stop fault
// - Disabled phase gives no indication or fault
// - Fast current limit alone gives no indication
`ifndef STALL_PARAMS_SVH
`define STALL_PARAMS_SVH
`define SP_CLK_HZ 50000000
`define SP_MIN_ON_MS 100
`define SP_TICK_MS 100
`define SP_TRIP_S 3
`define SP_TRIP_FREQ 16'h0064
`define SP_FMAX 32'h0000_9C40
`define SP_NONE 16'h270F
`define SP_K_UNIT 16'h0064
`define SP_CODE_IND 8'h03
`define SP_CODE_IND_N 8'h67
`define SP_CODE_SEL2 6'h03
`define SP_VRS_ON 8'h0B
`define SP_SEL_DRV 8'h64
`define SP_SEL_DRV_NF 8'h65
`define SP_DIS_STOP 4
`define SP_A_LEVEL 8'h00
`define SP_A_COMP 8'h04
`define SP_A_RSTART 8'h08
`define SP_A_LEVEL2 8'h0C
`define SP_A_VRS 8'h10
`define SP_A_SEL 8'h14
`define SP_A_DLY 8'h18
`define SP_A_TFUN 8'h1C
`define SP_A_IFUN 8'h20
`define SP_A_STATUS 8'h24
`define SP_A_LVLNOW 8'h28
`define SP_A_FAULT 8'h2C
`define SP_R_LEVEL 16'h05DC
`define SP_R_RSTART 16'h1388
`define SP_R_VRS 8'h01
`endif

// >>> core/stall_pkg.sv
// Types and helpers shared by the stall prevention block
package stall_pkg;
  `include "stall_params.svh"

  // Ramp phase seen by the limiter
  typedef enum logic [1:0] {PH_CONST, PH_ACCEL, PH_DECEL} phase_e;
  // Instruction to the frequency ramp
  typedef enum logic [1:0] {RAMP_FOLLOW, RAMP_ACCEL, RAMP_DECEL} ramp_e;
  // Level calculation steps
  typedef enum logic [2:0] {CALC_IDLE, CALC_A, CALC_B, CALC_T} calc_e;

  // Disable mask {stop, dec, const, acc, fast} from the selection code
  function automatic logic [4:0] sel_disables(input logic [7:0] sel, input logic regen);
    logic [4:0] d;
    d = sel[4:0];
    if (sel == `SP_SEL_DRV || sel == `SP_SEL_DRV_NF) begin
      // Mode codes: one mode runs, the other is fully off
      d = regen ? 5'h0F : {4'h0, sel == `SP_SEL_DRV_NF};
    end
    return d;
  endfunction

  // Saturate a wide quotient to a 16-bit level
  function automatic logic [15:0] sat16(input logic [47:0] v);
    return (v > 48'h0000_0000_FFFF) ? 16'hFFFF : v[15:0];
  endfunction

  // Drive of one output terminal from its function code
  function automatic logic term_drive(input logic [7:0] code, input logic ind);
    return (code == `SP_CODE_IND) ? ind : ((code == `SP_CODE_IND_N) ? !ind : 1'b0);
  endfunction
endpackage

// >>> core/stall_sync.sv
// Two-flop synchroniser for pins from the power stage
`timescale 1ns/1ps
`default_nettype none
module stall_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q; // First stage, read only by q

  // Plain double flop; multi-bit words are assumed slow moving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> core/stall_divider.sv
// Serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module stall_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [47:0] num,
  input wire logic [31:0] den,
  output logic busy,
  output logic done,
  output logic [47:0] quo
);
  logic [31:0] den_q; // Latched divisor
  logic [31:0] rem_q; // Partial remainder
  logic [5:0] cnt_q; // Bits left
  logic [32:0] trial; // Shifted remainder less divisor

  assign trial = {1'b0, rem_q[30:0], quo[47]} - {1'b0, den_q};

  // A zero divisor yields all ones, which later saturates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      den_q <= '0;
      rem_q <= '0;
      cnt_q <= '0;
      quo <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        quo <= num;
        den_q <= den;
        rem_q <= '0;
        cnt_q <= 6'd48;
        busy <= 1'b1;
      end else if (busy) begin
        if (!trial[32] && !rem_q[31]) begin
          rem_q <= trial[31:0];
          quo <= {quo[46:0], 1'b1};
        end else begin
          rem_q <= {rem_q[30:0], quo[47]};
          quo <= {quo[46:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'd1;
        if (cnt_q == 6'd1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/stall_prevention.sv
// Stall prevention current limit with APB register access
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "stall_params.svh"
module stall_prevention #(
  parameter int unsigned MIN_ON_CYC = `SP_MIN_ON_MS * (`SP_CLK_HZ / 1000),
  parameter int unsigned TICK_CYC = `SP_TICK_MS * (`SP_CLK_HZ / 1000),
  parameter int unsigned TRIP_CYC = `SP_TRIP_S * `SP_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] output_current,
  input wire logic [4:0] terminal_in,
  input wire logic regen_mode,
  input wire logic [15:0] command_freq,
  input wire logic [15:0] output_freq,
  input wire logic regen_avoid_active,
  input wire logic ov_stall_active,
  output stall_pkg::ramp_e ramp_cmd,
  output logic stall_active,
  output logic voltage_reduce,
  output logic fast_limit_enable,
  output logic overload_indication,
  output logic [2:0] terminal_out,
  output logic stall_stop_fault,
  output logic second_function_select
);
  import stall_pkg::*;

  // Software settings
  logic [15:0] stall_threshold_percent_q; // Base level, 0.1 %
  logic [15:0] comp_factor_q; // Double-speed factor, %
  logic [15:0] reduction_start_freq_q; // 0.01 Hz
  logic [15:0] second_stall_threshold_q; // 0.1 %
  logic [7:0] voltage_reduction_sel_q;
  logic [7:0] stall_operation_sel_q;
  logic [15:0] overload_delay_q; // 0.1 s
  logic [23:0] out_fun_q; // Three 8-bit terminal codes
  logic [29:0] in_fun_q; // Five 6-bit terminal codes

  // Bus
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic wr_en;

  // Sensed pins
  logic [15:0] cur_s;
  logic [4:0] tin_s;
  logic regen_s;

  // Control state
  phase_e phase_q;
  ramp_e ramp_q;
  calc_e calc_q;
  logic sel2_q;
  logic sel2_d;
  logic stall_q;
  logic stall_d;
  logic phase_en;
  logic [4:0] dis;
  logic [15:0] lvl_q; // Level in force
  logic [15:0] lsel;
  logic [15:0] a_q;
  logic [15:0] b_q;
  logic [15:0] la;
  logic [15:0] lb;
  logic [15:0] kd;
  logic div_start_q;
  logic [47:0] num_q;
  logic [31:0] den_q;
  logic div_busy;
  logic div_done;
  logic [47:0] div_quo;
  logic src;
  logic src_q;
  logic pend;
  logic [31:0] tick_q;
  logic [15:0] dcnt_q;
  logic ind_q;
  logic [31:0] mcnt_q;
  logic [2:0] term_q;
  logic [31:0] trip_q;
  logic fault_q;
  logic fault_set;
  logic fault_clr;
  logic vred_q;
  logic fast_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ramp_cmd = ramp_q;
  assign stall_active = stall_q;
  assign voltage_reduce = vred_q;
  assign fast_limit_enable = fast_q;
  assign overload_indication = ind_q;
  assign terminal_out = term_q;
  assign stall_stop_fault = fault_q;
  assign second_function_select = sel2_q;

  // Current and terminal pins come from another domain
  stall_sync #(.WIDTH(22)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({output_current, terminal_in, regen_mode}),
    .q({cur_s, tin_s, regen_s})
  );

  // Divider shared by the three steps of the level formula
  stall_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start_q),
    .num(num_q),
    .den(den_q),
    .busy(div_busy),
    .done(div_done),
    .quo(div_quo)
  );

  // Write strobe at the completing access edge only
  assign wr_en = psel && penable && pwrite && pready_q;

  // Read mux; unmapped reads return zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (paddr)
      `SP_A_LEVEL: rd_d = {16'h0000, stall_threshold_percent_q};
      `SP_A_COMP: rd_d = {16'h0000, comp_factor_q};
      `SP_A_RSTART: rd_d = {16'h0000, reduction_start_freq_q};
      `SP_A_LEVEL2: rd_d = {16'h0000, second_stall_threshold_q};
      `SP_A_VRS: rd_d = {24'h00_0000, voltage_reduction_sel_q};
      `SP_A_SEL: rd_d = {24'h00_0000, stall_operation_sel_q};
      `SP_A_DLY: rd_d = {16'h0000, overload_delay_q};
      `SP_A_TFUN: rd_d = {8'h00, out_fun_q};
      `SP_A_IFUN: rd_d = {2'b00, in_fun_q};
      `SP_A_STATUS: rd_d = {24'h00_0000, sel2_q, vred_q, ind_q, stall_q, phase_q, ramp_q};
      `SP_A_LVLNOW: rd_d = {16'h0000, lvl_q};
      `SP_A_FAULT: rd_d = {31'h0000_0000, fault_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // No wait state: answer prepared in setup, ready on first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_q <= 1'b1;
      prdata_q <= rd_d;
      pslverr_q <= (paddr[1:0] != 2'b00) || (paddr > `SP_A_FAULT);
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Settings registers; read-only and unmapped writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_threshold_percent_q <= `SP_R_LEVEL;
      comp_factor_q <= `SP_NONE;
      reduction_start_freq_q <= `SP_R_RSTART;
      second_stall_threshold_q <= `SP_R_LEVEL;
      voltage_reduction_sel_q <= `SP_R_VRS;
      stall_operation_sel_q <= 8'h00;
      overload_delay_q <= 16'h0000;
      out_fun_q <= 24'h00_0000;
      in_fun_q <= 30'h0000_0000;
    end else if (wr_en) begin
      case (paddr)
        `SP_A_LEVEL: stall_threshold_percent_q <= pwdata[15:0];
        `SP_A_COMP: comp_factor_q <= pwdata[15:0];
        `SP_A_RSTART: reduction_start_freq_q <= pwdata[15:0];
        `SP_A_LEVEL2: second_stall_threshold_q <= pwdata[15:0];
        `SP_A_VRS: voltage_reduction_sel_q <= pwdata[7:0];
        `SP_A_SEL: stall_operation_sel_q <= pwdata[7:0];
        `SP_A_DLY: overload_delay_q <= pwdata[15:0];
        `SP_A_TFUN: out_fun_q <= pwdata[23:0];
        `SP_A_IFUN: in_fun_q <= pwdata[29:0];
        default: ;
      endcase
    end
  end

  // Second function select from any terminal coded for it
  always_comb begin
    sel2_d = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (in_fun_q[i*6 +: 6] == `SP_CODE_SEL2 && tin_s[i]) begin
        sel2_d = 1'b1;
      end
    end
  end

  // Phase and select, registered once per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= PH_CONST;
      sel2_q <= 1'b0;
    end else begin
      sel2_q <= sel2_d;
      if (command_freq > output_freq) begin
        phase_q <= PH_ACCEL;
      end else if (command_freq < output_freq) begin
        phase_q <= PH_DECEL;
      end else begin
        phase_q <= PH_CONST;
      end
    end
  end

  // Formula operands
  assign lsel = sel2_q ? second_stall_threshold_q : stall_threshold_percent_q;
  assign la = (lsel > a_q) ? lsel - a_q : 16'h0000;
  assign lb = (lsel > b_q) ? lsel - b_q : 16'h0000;
  assign kd = (comp_factor_q >= `SP_K_UNIT) ? comp_factor_q - `SP_K_UNIT : `SP_K_UNIT - comp_factor_q;

  // Level calculation; the level in force holds until a pass ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calc_q <= CALC_IDLE;
      lvl_q <= `SP_R_LEVEL;
      a_q <= 16'h0000;
      b_q <= 16'h0000;
      num_q <= '0;
      den_q <= '0;
      div_start_q <= 1'b0;
    end else begin
      div_start_q <= 1'b0;
      case (calc_q)
        CALC_IDLE: begin
          if (comp_factor_q == `SP_NONE || output_freq <= reduction_start_freq_q) begin
            lvl_q <= lsel;
          end else begin
            num_q <= 48'(reduction_start_freq_q * lsel);
            den_q <= {16'h0000, output_freq};
            div_start_q <= 1'b1;
            calc_q <= CALC_A;
          end
        end
        CALC_A: begin
          if (div_done) begin
            a_q <= sat16(div_quo);
            den_q <= `SP_FMAX;
            div_start_q <= 1'b1;
            calc_q <= CALC_B;
          end
        end
        CALC_B: begin
          if (div_done) begin
            b_q <= sat16(div_quo);
            calc_q <= CALC_T;
          end
        end
        CALC_T: begin
          // Operands settle one cycle after B, then the last division runs
          if (!div_busy && !div_start_q && !div_done) begin
            num_q <= 48'(b_q * la * kd);
            den_q <= 32'(lb * `SP_K_UNIT);
            div_start_q <= 1'b1;
          end else if (div_done) begin
            if (comp_factor_q >= `SP_K_UNIT) begin
              lvl_q <= sat16(48'(a_q) + div_quo);
            end else begin
              lvl_q <= (div_quo > 48'(a_q)) ? 16'h0000 : a_q - div_quo[15:0];
            end
            calc_q <= CALC_IDLE;
          end
        end
        default: calc_q <= CALC_IDLE;
      endcase
    end
  end

  // Per-phase enables from the selection code
  assign dis = sel_disables(stall_operation_sel_q, regen_s);
  always_comb begin
    case (phase_q)
      PH_ACCEL: phase_en = !dis[1];
      PH_CONST: phase_en = !dis[2];
      PH_DECEL: phase_en = !dis[3];
      default: phase_en = 1'b0;
    endcase
  end
  assign stall_d = (cur_s > lvl_q) && phase_en;

  // Stall state, ramp steering, voltage reduction, fast limit enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_q <= 1'b0;
      ramp_q <= RAMP_FOLLOW;
      vred_q <= 1'b0;
      fast_q <= 1'b1;
    end else begin
      stall_q <= stall_d;
      fast_q <= !dis[0];
      vred_q <= stall_d && voltage_reduction_sel_q == `SP_VRS_ON;
      if (!stall_d) begin
        ramp_q <= RAMP_FOLLOW;
      end else if (phase_q == PH_DECEL) begin
        ramp_q <= RAMP_ACCEL;
      end else begin
        ramp_q <= RAMP_DECEL;
      end
    end
  end

  // Indication sources; fast limiting is deliberately not one
  assign src = stall_q || regen_avoid_active || ov_stall_active;
  assign pend = src && overload_delay_q != `SP_NONE && dcnt_q >= overload_delay_q;

  // Delay timer in 0.1 s steps, cleared whenever the source is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 1'b0;
      tick_q <= '0;
      dcnt_q <= 16'h0000;
    end else begin
      src_q <= src;
      if (!src || !src_q) begin
        tick_q <= '0;
        dcnt_q <= 16'h0000;
      end else if (tick_q >= TICK_CYC - 1) begin
        tick_q <= '0;
        if (dcnt_q != 16'hFFFF) begin
          dcnt_q <= dcnt_q + 16'h0001;
        end
      end else begin
        tick_q <= tick_q + 32'd1;
      end
    end
  end

  // Indication with minimum on-time; drops when no longer pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_q <= 1'b0;
      mcnt_q <= '0;
    end else begin
      ind_q <= pend || (ind_q && mcnt_q < MIN_ON_CYC);
      if (!ind_q) begin
        mcnt_q <= '0;
      end else if (mcnt_q < MIN_ON_CYC) begin
        mcnt_q <= mcnt_q + 32'd1;
      end
    end
  end

  // Output terminals follow the indication at chosen polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_q <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        term_q[i] <= term_drive(out_fun_q[i*8 +: 8], ind_q);
      end
    end
  end

  // Low-frequency stall timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_q <= '0;
    end else if (stall_q && output_freq <= `SP_TRIP_FREQ) begin
      if (trip_q < TRIP_CYC) begin
        trip_q <= trip_q + 32'd1;
      end
    end else begin
      trip_q <= '0;
    end
  end

  // Fault is sticky; a set in the clearing cycle wins
  assign fault_set = (trip_q >= TRIP_CYC - 1) || (dis[`SP_DIS_STOP] && ind_q);
  assign fault_clr = wr_en && paddr == `SP_A_FAULT && pwdata[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_set || (fault_q && !fault_clr);
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ind_rise;
    !ind_q ##1 ind_q;
  endsequence
  sequence s_ind_fall;
    ind_q ##1 !ind_q;
  endsequence

  a_ind_min_on: assert property (s_ind_rise |-> ind_q [*8])
    else $error("overload indication too short");
  a_ind_fall_time: assert property (s_ind_fall |-> $past(mcnt_q) >= MIN_ON_CYC && !$past(pend))
    else $error("overload indication dropped early");
  a_ind_cause: assert property (s_ind_rise |-> $past(pend) && $past(src))
    else $error("overload indication without cause");
  a_ind_suppress: assert property (s_ind_rise |-> $past(overload_delay_q) != `SP_NONE)
    else $error("suppressed indication asserted");
  a_ind_immediate: assert property (overload_delay_q == 16'h0000 && src |=> ind_q)
    else $error("zero delay not immediate");
  a_ramp_reverse: assert property (stall_d && phase_q == PH_DECEL |=> ramp_q == RAMP_ACCEL)
    else $error("deceleration not halted");
  a_ramp_slow: assert property (stall_d && phase_q != PH_DECEL |=> ramp_q == RAMP_DECEL)
    else $error("acceleration not halted");
  a_stall_gate: assert property (stall_q |-> $past(phase_en) && $past(cur_s) > $past(lvl_q))
    else $error("stall in disabled phase");
  a_term_pol: assert property (out_fun_q[7:0] == `SP_CODE_IND_N ##1 out_fun_q[7:0] == `SP_CODE_IND_N |-> term_q[0] == !$past(ind_q))
    else $error("inverted terminal wrong");
  a_fault_hold: assert property (fault_q && !fault_clr |=> fault_q)
    else $error("fault lost");
endmodule
`default_nettype wire

// >>> tb/drive_stage_model.sv
// Model of the power stage: frequency ramp and output current sensing
`timescale 1ns/1ps
`default_nettype none
module drive_stage_model (
  input wire stall_pkg::ramp_e ramp_cmd,
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] command_freq,
  input wire logic [15:0] load_current,
  output logic [15:0] output_current,
  output logic [15:0] output_freq
);
  import stall_pkg::*;
  // Sensed current lags the load by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_current <= 16'h0000;
    end else begin
      output_current <= load_current;
    end
  end
  // Steps of 1 Hz per cycle, so a phase survives the few cycles of detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_freq <= 16'h0000;
    end else if (ramp_cmd == RAMP_ACCEL) begin
      output_freq <= output_freq + 16'h0064;
    end else if (ramp_cmd == RAMP_DECEL) begin
      // Floor at zero: a stalled drive never goes negative
      output_freq <= (output_freq < 16'h0064) ? 16'h0000 : output_freq - 16'h0064;
    end else if (command_freq >= output_freq + 16'h0064) begin
      output_freq <= output_freq + 16'h0064;
    end else if (output_freq >= command_freq + 16'h0064) begin
      output_freq <= output_freq - 16'h0064;
    end else begin
      output_freq <= command_freq;
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_stall_prevention.sv
// Self-checking testbench for the stall prevention block
`timescale 1ns/1ps
`default_nettype none
`include "stall_params.svh"
module test_stall_prevention;
  import stall_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [15:0] output_current, output_freq;
  logic [15:0] command_freq = 16'h1388;
  logic [15:0] load_current = 16'h03E8;
  logic [4:0] terminal_in = 5'h00;
  logic regen_mode = 1'b0;
  logic regen_avoid_active = 1'b0;
  logic ov_stall_active = 1'b0;
  ramp_e ramp_cmd;
  logic stall_active, voltage_reduce, fast_limit_enable, overload_indication;
  logic stall_stop_fault, second_function_select;
  logic [2:0] terminal_out;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // Phase table: selection code, regen mode, command, stall expected, ramp expected
  logic [7:0] t_sel [8] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h08, 8'h64, 8'h64};
  logic [7:0] t_rgn = 8'h40;
  logic [15:0] t_cmd [8] = '{16'h1388, 16'h2328, 16'h03E8, 16'h1388, 16'h2328, 16'h03E8, 16'h1388, 16'h1388};
  logic [7:0] t_stl = 8'h87;
  ramp_e t_rmp [8] = '{RAMP_DECEL, RAMP_DECEL, RAMP_ACCEL, RAMP_FOLLOW, RAMP_FOLLOW, RAMP_FOLLOW, RAMP_FOLLOW, RAMP_DECEL};

  // Small counts so that timers run out in tens of cycles
  stall_prevention #(.MIN_ON_CYC(20), .TICK_CYC(20), .TRIP_CYC(50)) i_stall_prevention (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_current(output_current), .terminal_in(terminal_in), .regen_mode(regen_mode),
    .command_freq(command_freq), .output_freq(output_freq), .regen_avoid_active(regen_avoid_active),
    .ov_stall_active(ov_stall_active), .ramp_cmd(ramp_cmd), .stall_active(stall_active),
    .voltage_reduce(voltage_reduce), .fast_limit_enable(fast_limit_enable),
    .overload_indication(overload_indication), .terminal_out(terminal_out),
    .stall_stop_fault(stall_stop_fault), .second_function_select(second_function_select));

  drive_stage_model i_drive_stage_model (.pclk(pclk), .presetn(presetn), .ramp_cmd(ramp_cmd),
    .command_freq(command_freq), .load_current(load_current), .output_current(output_current),
    .output_freq(output_freq));

  // 50 MHz clock
  always #10 pclk = ~pclk;

  // Hang guard: far above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      final_report();
    end
  end

  // One comparison, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // APB transfer; waits for pready, the hang guard bounds the wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Bring the ramp to a set point before a stall
  task automatic go_freq(input logic [15:0] f);
    command_freq <= f;
    for (int i = 0; i < 200; i++) begin
      @(posedge pclk);
      if (output_freq === f) break;
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(4);
    presetn <= 1'b1;
    // Register defaults, then an unmapped place
    apb(1'b0, `SP_A_LEVEL, 32'h0, rd, er);
    check(rd, 32'h0000_05DC);
    apb(1'b0, `SP_A_COMP, 32'h0, rd, er);
    check(rd, 32'h0000_270F);
    apb(1'b0, 8'h30, 32'h0, rd, er);
    check({31'h0, er}, 32'h0000_0001);
    check(fast_limit_enable, 1'b1);
    wr(`SP_A_TFUN, 32'h0000_6703);
    wr(`SP_A_IFUN, 32'h0000_0003);
    // Each ramp phase, enabled and disabled by the selection code
    for (int k = 0; k < 8; k++) begin
      wr(`SP_A_SEL, {24'h0, t_sel[k]});
      regen_mode <= t_rgn[k];
      go_freq(16'h1388);
      command_freq <= t_cmd[k];
      load_current <= 16'h0640;
      cyc(7);
      check(stall_active, t_stl[k]);
      check(ramp_cmd, t_rmp[k]);
      check(overload_indication, t_stl[k]);
      check(terminal_out, t_stl[k] ? 3'b001 : 3'b010);
      load_current <= 16'h03E8;
      cyc(60);
      check(overload_indication, 1'b0);
    end
    regen_mode <= 1'b0;
    wr(`SP_A_SEL, 32'h0000_0001);
    cyc(1);
    check(fast_limit_enable, 1'b0);
    wr(`SP_A_SEL, 32'h0000_0000);
    // One-cycle overcurrent still gives the minimum on-time
    go_freq(16'h1388);
    load_current <= 16'h0640;
    @(posedge pclk);
    load_current <= 16'h03E8;
    cyc(18);
    check(overload_indication, 1'b1);
    cyc(40);
    check(overload_indication, 1'b0);
    // Delay settings: none, one step, early end
    wr(`SP_A_DLY, 32'h0000_270F);
    load_current <= 16'h0640;
    cyc(8);
    check({stall_active, overload_indication}, 2'b10);
    load_current <= 16'h03E8;
    go_freq(16'h1388);
    wr(`SP_A_DLY, 32'h0000_0001);
    load_current <= 16'h0640;
    cyc(12);
    check(overload_indication, 1'b0);
    cyc(30);
    check(overload_indication, 1'b1);
    load_current <= 16'h03E8;
    go_freq(16'h1388);
    load_current <= 16'h0640;
    cyc(8);
    load_current <= 16'h03E8;
    cyc(40);
    check(overload_indication, 1'b0);
    wr(`SP_A_DLY, 32'h0000_0000);
    // Second level chosen by the input terminal
    wr(`SP_A_LEVEL2, 32'h0000_03E8);
    go_freq(16'h1388);
    load_current <= 16'h04B0;
    cyc(8);
    check(stall_active, 1'b0);
    terminal_in <= 5'h01;
    cyc(8);
    check({second_function_select, stall_active}, 2'b11);
    apb(1'b0, `SP_A_LVLNOW, 32'h0, rd, er);
    check(rd, 32'h0000_03E8);
    load_current <= 16'h03E8;
    terminal_in <= 5'h00;
    // Voltage reduction with selection 11, off again once the stall ends
    wr(`SP_A_VRS, 32'h0000_000B);
    go_freq(16'h1388);
    load_current <= 16'h0640;
    cyc(8);
    check(voltage_reduce, 1'b1);
    load_current <= 16'h03E8;
    cyc(30);
    check({voltage_reduce, overload_indication}, 2'b00);
    // Other stall functions also indicate
    regen_avoid_active <= 1'b1;
    cyc(6);
    check(overload_indication, 1'b1);
    regen_avoid_active <= 1'b0;
    ov_stall_active <= 1'b1;
    cyc(30);
    check(overload_indication, 1'b1);
    ov_stall_active <= 1'b0;
    cyc(40);
    // Stall held near 1 Hz trips after the trip count
    go_freq(16'h00C8);
    load_current <= 16'h0640;
    cyc(30);
    check(stall_stop_fault, 1'b0);
    cyc(70);
    check(stall_stop_fault, 1'b1);
    load_current <= 16'h03E8;
    cyc(8);
    wr(`SP_A_FAULT, 32'h0000_0001);
    check(stall_stop_fault, 1'b0);
    // Level reduced above the start frequency, recommended settings
    wr(`SP_A_COMP, 32'h0000_0064);
    load_current <= 16'h0064;
    go_freq(16'h2710);
    cyc(400);
    apb(1'b0, `SP_A_LVLNOW, 32'h0, rd, er);
    check(rd, 32'h0000_02EE);
    // Weight 16 stops the drive on the indication
    wr(`SP_A_SEL, 32'h0000_0010);
    go_freq(16'h1388);
    load_current <= 16'h0640;
    cyc(8);
    check(stall_stop_fault, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
